// [logic/scl_map.svh]
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH

`define SCL_CLK_MHZ         20
`define SCL_T_CF2ST0_NS     600
`define SCL_CF2ST0_CYC      ((`SCL_T_CF2ST0_NS * `SCL_CLK_MHZ) / 1000)
`define SCL_T_STATUS_MIN_US 268
`define SCL_STATUS_MIN_CYC  (`SCL_T_STATUS_MIN_US * `SCL_CLK_MHZ)
`define SCL_T_STATUS_MAX_US 1506
`define SCL_STATUS_MAX_CYC  (`SCL_T_STATUS_MAX_US * `SCL_CLK_MHZ)
`define SCL_T_CD2UM_MIN_US  175
`define SCL_T_CD2UM_MAX_US  437
`define SCL_CD2UM_CYC       (`SCL_T_CD2UM_MIN_US * `SCL_CLK_MHZ)
`define SCL_T_CD2CU_NS      40
`define SCL_CD2CU_CYC       ((`SCL_T_CD2CU_NS * `SCL_CLK_MHZ + 999) / 1000)
`define SCL_USR_INIT_CYC    8576
`define SCL_POR_CYC         2000
`define SCL_CFG_BITS        1024
`define SCL_DONE_FALLS      2'h2
`define SCL_CMD_BITS        24'h20
`define SCL_RD_WORD         32'h0300_0000
`define SCL_QUAD_STEP       24'h4
`define SCL_SER_STEP        24'h1

`define SCL_HALF_SEL0       4'h8
`define SCL_HALF_SEL1       4'h4
`define SCL_HALF_SEL2       4'h2
`define SCL_HALF_SEL3       4'h1
`define SCL_SEL_NOMAX       2'h3
`define SCL_SEL_FALLBACK    2'h2

`define SCL_SY_W            9
`define SCL_SY_REQ          0
`define SCL_SY_STAT         1
`define SCL_SY_CLK          2
`define SCL_SY_DATA         3
`define SCL_SY_USR          4
`define SCL_SY_QLO          5
`define SCL_SY_QHI          8
`define SCL_SY_RST          9'h001

`endif

// [logic/scl_pkg.sv]
package scl_pkg;

  typedef enum logic [3:0] {
    S_POR,
    S_RESET,
    S_RELEASE,
    S_CMD,
    S_LOAD,
    S_COMPLETE,
    S_INIT_OSC,
    S_INIT_WAIT,
    S_INIT_USR,
    S_USER
  } scl_state_t;

  typedef logic [1:0] scl_rate_t;

endpackage

// [logic/scl_pin_sync.sv]
`timescale 1ns/1ps
module scl_pin_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  // pins in, filtered levels out
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] lvl_reg;
  logic [WIDTH-1:0] lvl_next;

  // a bit moves only once stages two and three agree
  always_comb begin
    lvl_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (lvl_reg & (s2_reg ^ s3_reg));
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_reg  <= RST_VAL;
      s2_reg  <= RST_VAL;
      s3_reg  <= RST_VAL;
      lvl_reg <= RST_VAL;
    end else begin
      s1_reg  <= i_pin;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign o_level = lvl_reg;

endmodule

// [logic/scl_loader.sv]
`timescale 1ns/1ps
`include "scl_map.svh"
// Operation
// - active clock in four selectable rate ranges
// - chained devices never use top rate
// - quad mode takes four bits per cycle
// - init clock from oscillator or user clock
// - flash output launched on clock falling edge
// - request low in user mode restarts
// - complete and status low within 600 ns
// - status low between 268 and 1506 us; code holds it 268 us minimum, no maximum
// - status released after request returns high
// - externally held status low postpones loading
// - status low through power-on delay
// - complete low until data accepted
// - complete rises only after all data
// - data pin becomes user pin afterwards
// - init-done pin low until initialization ends
// - oscillator init lasts 175 to 437 us
// - user clock init needs 8576 cycles
module scl_loader
  import scl_pkg::*;
#(
  parameter int CONFIG_BITS    = `SCL_CFG_BITS,
  parameter int POR_CYC        = `SCL_POR_CYC,
  parameter int STATUS_MIN_CYC = `SCL_STATUS_MIN_CYC,
  parameter int USR_INIT_CYC   = `SCL_USR_INIT_CYC
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // options
  input  wire logic       i_active_serial_scheme,
  input  wire logic       i_quad_mode,
  input  wire scl_rate_t  i_rate_sel,
  input  wire logic       i_multi_device,
  input  wire logic       i_use_user_clk,
  input  wire logic       i_init_done_opt,
  input  wire logic       i_data_pin_user,
  // handshake pins
  input  wire logic       i_config_request_n,
  input  wire logic       i_config_status_n,
  output logic            o_config_status_n,
  output logic            o_config_status_n_oe,
  output logic            o_config_complete,
  // configuration clock pin
  input  wire logic       i_config_clock,
  output logic            o_config_clock,
  output logic            o_config_clock_oe,
  // data pins
  input  wire logic       i_serial_config_data,
  input  wire logic [3:0] i_quad_flash_bus,
  output logic            o_flash_serial_out,
  output logic            o_flash_select_n,
  input  wire logic       i_user_init_clock,
  // initialization
  output logic            o_init_done,
  output logic            o_init_done_oe,
  output logic            o_user_mode,
  output logic            o_user_io_data,
  // accepted configuration data
  output logic [3:0]      o_cfg_bits,
  output logic            o_cfg_bits_wide,
  output logic            o_cfg_valid
);

  localparam logic [15:0] POR_LIM = 16'(POR_CYC - 1);
  localparam logic [15:0] ST_LIM  = 16'(STATUS_MIN_CYC - 1);
  localparam logic [15:0] OSC_LIM = 16'(`SCL_CD2UM_CYC - 1);
  localparam logic [15:0] CU_LIM  = 16'(`SCL_CD2CU_CYC);
  localparam logic [15:0] USR_LIM = 16'(USR_INIT_CYC - 1);
  localparam logic [23:0] CFG_LIM = 24'(CONFIG_BITS);

  ////////////////////////////////////////////////////////////////////////
  // pin sampling

  logic [`SCL_SY_W-1:0] sy_lvl;
  logic                 req_hi;
  logic                 stat_hi;
  logic                 sy_clk;
  logic                 sy_data;
  logic                 sy_usr;
  logic [3:0]           sy_quad;

  scl_pin_sync #(
    .WIDTH   (`SCL_SY_W),
    .RST_VAL (`SCL_SY_RST)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_pin   ({i_quad_flash_bus, i_user_init_clock, i_serial_config_data,
               i_config_clock, i_config_status_n, i_config_request_n}),
    .o_level (sy_lvl)
  );

  assign req_hi  = sy_lvl[`SCL_SY_REQ];
  assign stat_hi = sy_lvl[`SCL_SY_STAT];
  assign sy_clk  = sy_lvl[`SCL_SY_CLK];
  assign sy_data = sy_lvl[`SCL_SY_DATA];
  assign sy_usr  = sy_lvl[`SCL_SY_USR];
  assign sy_quad = sy_lvl[`SCL_SY_QHI:`SCL_SY_QLO];

  ////////////////////////////////////////////////////////////////////////
  // state

  scl_state_t  state_reg,   state_next;
  logic [15:0] tmr_reg,     tmr_next;
  logic [23:0] bit_cnt_reg, bit_cnt_next;
  logic [31:0] cmd_reg,     cmd_next;
  logic [1:0]  fall_reg,    fall_next;
  logic [3:0]  div_reg,     div_next;
  scl_rate_t   sel_reg,     sel_next;
  logic        cclk_reg,    cclk_next;
  logic        pclk_reg,    pusr_reg;
  logic        so_reg,      so_next;
  logic        cs_n_reg,    cs_n_next;
  logic        st_oe_reg,   st_oe_next;
  logic        cmpl_reg,    cmpl_next;
  logic        clk_oe_reg,  clk_oe_next;
  logic        init_oe_reg, init_oe_next;
  logic        user_reg,    user_next;
  logic        uio_reg,     uio_next;
  logic [3:0]  bits_reg,    bits_next;
  logic        wide_reg,    wide_next;
  logic        valid_reg,   valid_next;
  logic        lo_reg;
  logic [3:0]  half;
  logic        clk_run;
  logic        as_fall;
  logic        fall_ev;
  logic        smp_ev;
  logic [23:0] bit_add;

  always_comb begin
    case (sel_reg)
      2'h0:    half = `SCL_HALF_SEL0;
      2'h1:    half = `SCL_HALF_SEL1;
      2'h2:    half = `SCL_HALF_SEL2;
      default: half = `SCL_HALF_SEL3;
    endcase
  end

  // clock idles high so the first toggle is a launching fall
  assign clk_run = i_active_serial_scheme &&
                   (state_reg inside {S_CMD, S_LOAD, S_COMPLETE});
  assign as_fall = clk_run && (div_reg == half - 4'h1) && cclk_reg;
  assign fall_ev = i_active_serial_scheme ? as_fall : (pclk_reg && !sy_clk);
  // active: flash data set up before our fall; passive: host rise
  assign smp_ev  = i_active_serial_scheme ? as_fall
                                          : (!pclk_reg && sy_clk);
  assign bit_add = bit_cnt_reg + ((i_active_serial_scheme && i_quad_mode)
                   ? `SCL_QUAD_STEP : `SCL_SER_STEP);

  always_comb begin
    state_next   = state_reg;
    tmr_next     = tmr_reg;
    bit_cnt_next = bit_cnt_reg;
    cmd_next     = cmd_reg;
    fall_next    = fall_reg;
    so_next      = so_reg;
    bits_next    = bits_reg;
    wide_next    = wide_reg;
    valid_next   = 1'b0;
    div_next     = div_reg;
    cclk_next    = cclk_reg;
    sel_next     = (i_multi_device && i_rate_sel == `SCL_SEL_NOMAX)
                   ? `SCL_SEL_FALLBACK : i_rate_sel;
    if (clk_run) begin
      if (div_reg == half - 4'h1) begin
        div_next  = 4'h0;
        cclk_next = !cclk_reg;
      end else begin
        div_next = div_reg + 4'h1;
      end
    end
    case (state_reg)
      S_POR: begin
        if (tmr_reg == POR_LIM) begin
          state_next = S_RELEASE;
          tmr_next   = 16'h0;
        end else begin
          tmr_next = tmr_reg + 16'h1;
        end
      end
      S_RESET: begin
        // park high while deselected, else select drops onto a stray rise
        cclk_next = 1'b1;
        if (tmr_reg != 16'hffff) begin
          tmr_next = tmr_reg + 16'h1;
        end
        if (req_hi && tmr_reg >= ST_LIM) begin
          state_next = S_RELEASE;
        end
      end
      S_RELEASE: begin
        if (stat_hi) begin
          tmr_next     = 16'h0;
          bit_cnt_next = 24'h0;
          fall_next    = 2'h0;
          cmd_next     = `SCL_RD_WORD;
          div_next     = 4'h0;
          cclk_next    = 1'b1;
          state_next   = i_active_serial_scheme ? S_CMD : S_LOAD;
        end
      end
      S_CMD: begin
        if (as_fall) begin
          if (bit_cnt_reg == `SCL_CMD_BITS) begin
            bit_cnt_next = 24'h0;
            state_next   = S_LOAD;
          end else begin
            so_next      = cmd_reg[31];
            cmd_next     = {cmd_reg[30:0], 1'b0};
            bit_cnt_next = bit_cnt_reg + `SCL_SER_STEP;
          end
        end
      end
      S_LOAD: begin
        if (smp_ev) begin
          valid_next   = 1'b1;
          bit_cnt_next = bit_add;
          wide_next    = i_active_serial_scheme && i_quad_mode;
          if (!i_active_serial_scheme) begin
            bits_next = {3'h0, sy_data};
          end else if (i_quad_mode) begin
            bits_next = sy_quad;
          end else begin
            bits_next = {3'h0, sy_quad[1]};
          end
          if (bit_add >= CFG_LIM) begin
            state_next = S_COMPLETE;
            fall_next  = 2'h0;
          end
        end
      end
      S_COMPLETE: begin
        if (fall_ev) begin
          fall_next = fall_reg + 2'h1;
          if (fall_reg == `SCL_DONE_FALLS - 2'h1) begin
            tmr_next   = 16'h0;
            state_next = i_use_user_clk ? S_INIT_WAIT : S_INIT_OSC;
          end
        end
      end
      S_INIT_OSC: begin
        if (tmr_reg == OSC_LIM) begin
          state_next = S_USER;
        end else begin
          tmr_next = tmr_reg + 16'h1;
        end
      end
      S_INIT_WAIT: begin
        // user clock is ignored until this hold-off has passed
        if (tmr_reg == CU_LIM) begin
          tmr_next   = 16'h0;
          state_next = S_INIT_USR;
        end else begin
          tmr_next = tmr_reg + 16'h1;
        end
      end
      S_INIT_USR: begin
        if (sy_usr && !pusr_reg) begin
          if (tmr_reg == USR_LIM) begin
            state_next = S_USER;
          end else begin
            tmr_next = tmr_reg + 16'h1;
          end
        end
      end
      S_USER: begin
        state_next = S_USER;
      end
      default: begin
        state_next = S_POR;
      end
    endcase
    // request low restarts from anywhere once power-on is over
    if (!req_hi && state_reg != S_POR && state_reg != S_RESET) begin
      state_next = S_RESET;
      tmr_next   = 16'h0;
    end
    st_oe_next   = state_next inside {S_POR, S_RESET};
    cmpl_next    = state_next inside {S_COMPLETE, S_INIT_OSC, S_INIT_WAIT,
                                      S_INIT_USR, S_USER};
    cs_n_next    = !(i_active_serial_scheme &&
                     (state_next inside {S_CMD, S_LOAD}));
    clk_oe_next  = i_active_serial_scheme;
    init_oe_next = i_init_done_opt &&
                   (state_next inside {S_COMPLETE, S_INIT_OSC, S_INIT_WAIT,
                                       S_INIT_USR});
    user_next    = state_next == S_USER;
    uio_next     = user_next && i_data_pin_user && sy_data;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg   <= S_POR;
      tmr_reg     <= 16'h0;
      bit_cnt_reg <= 24'h0;
      cmd_reg     <= 32'h0;
      fall_reg    <= 2'h0;
      div_reg     <= 4'h0;
      sel_reg     <= 2'h0;
      cclk_reg    <= 1'b1;
      pclk_reg    <= 1'b0;
      pusr_reg    <= 1'b0;
      so_reg      <= 1'b0;
      cs_n_reg    <= 1'b1;
      st_oe_reg   <= 1'b1;
      cmpl_reg    <= 1'b0;
      clk_oe_reg  <= 1'b0;
      init_oe_reg <= 1'b0;
      user_reg    <= 1'b0;
      uio_reg     <= 1'b0;
      bits_reg    <= 4'h0;
      wide_reg    <= 1'b0;
      valid_reg   <= 1'b0;
      lo_reg      <= 1'b0;
    end else begin
      state_reg   <= state_next;
      tmr_reg     <= tmr_next;
      bit_cnt_reg <= bit_cnt_next;
      cmd_reg     <= cmd_next;
      fall_reg    <= fall_next;
      div_reg     <= div_next;
      sel_reg     <= sel_next;
      cclk_reg    <= cclk_next;
      pclk_reg    <= sy_clk;
      pusr_reg    <= sy_usr;
      so_reg      <= so_next;
      cs_n_reg    <= cs_n_next;
      st_oe_reg   <= st_oe_next;
      cmpl_reg    <= cmpl_next;
      clk_oe_reg  <= clk_oe_next;
      init_oe_reg <= init_oe_next;
      user_reg    <= user_next;
      uio_reg     <= uio_next;
      bits_reg    <= bits_next;
      wide_reg    <= wide_next;
      valid_reg   <= valid_next;
      lo_reg      <= 1'b0;
    end
  end

  // open-drain lines only ever pull low
  assign o_config_status_n    = lo_reg;
  assign o_config_status_n_oe = st_oe_reg;
  assign o_config_complete    = cmpl_reg;
  assign o_config_clock       = cclk_reg;
  assign o_config_clock_oe    = clk_oe_reg;
  assign o_flash_serial_out   = so_reg;
  assign o_flash_select_n     = cs_n_reg;
  assign o_init_done          = lo_reg;
  assign o_init_done_oe       = init_oe_reg;
  assign o_user_mode          = user_reg;
  assign o_user_io_data       = uio_reg;
  assign o_cfg_bits           = bits_reg;
  assign o_cfg_bits_wide      = wide_reg;
  assign o_cfg_valid          = valid_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic [15:0] lo_cnt;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lo_cnt <= 16'h0;
    end else if (!st_oe_reg) begin
      lo_cnt <= 16'h0;
    end else if (lo_cnt != 16'hffff) begin
      lo_cnt <= lo_cnt + 16'h1;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence seq_user_req;
    state_reg == S_USER && !req_hi;
  endsequence

  sequence seq_osc_exit;
    state_reg == S_INIT_OSC ##1 state_reg == S_USER;
  endsequence

  AST_REQ_STATUS_LOW: assert property (
    seq_user_req |-> ##[1:2] o_config_status_n_oe)
    else $error("status not pulled low after request");
  AST_REQ_COMPLETE_LOW: assert property (
    seq_user_req |-> ##[1:2] !o_config_complete)
    else $error("complete not low after request");
  AST_STATUS_WIDTH: assert property (
    $fell(o_config_status_n_oe) && state_reg == S_RELEASE &&
    $past(state_reg) == S_RESET |-> $past(lo_cnt) >= ST_LIM)
    else $error("status low pulse too short");
  AST_STATUS_RELEASE: assert property (
    state_reg == S_RESET && req_hi && tmr_reg >= ST_LIM
    |-> ##[1:2] !o_config_status_n_oe)
    else $error("status not released");
  AST_HOLD_EXT: assert property (
    state_reg == S_RELEASE && !stat_hi && req_hi
    |=> state_reg == S_RELEASE && !o_config_complete)
    else $error("loading went on while status held low");
  AST_RATE_CAP: assert property (
    i_multi_device |=> sel_reg != `SCL_SEL_NOMAX)
    else $error("top rate used in chained setup");
  AST_LAUNCH_FALL: assert property (
    i_active_serial_scheme && $changed(o_flash_serial_out)
    |-> $fell(o_config_clock))
    else $error("flash output changed off a falling edge");
  AST_QUAD_STEP: assert property (
    o_cfg_valid && o_cfg_bits_wide
    |-> bit_cnt_reg == $past(bit_cnt_reg) + `SCL_QUAD_STEP)
    else $error("quad capture did not take four bits");
  AST_DONE_AFTER_DATA: assert property (
    $rose(o_config_complete) |-> bit_cnt_reg >= CFG_LIM)
    else $error("complete rose before all data");
  AST_TWO_FALLS: assert property (
    $past(state_reg) == S_COMPLETE &&
    state_reg inside {S_INIT_OSC, S_INIT_WAIT} |-> fall_reg == 2'h2)
    else $error("initialization began without two falls");
  AST_INIT_PIN: assert property (
    o_init_done_oe |-> !o_user_mode && o_config_complete)
    else $error("init-done pin low outside initialization");
  AST_OSC_TIME: assert property (
    seq_osc_exit |-> $past(tmr_reg) == OSC_LIM && o_user_mode &&
    !$past(o_user_mode))
    else $error("oscillator initialization length wrong");

endmodule

// [dv/scl_cfg_host.sv]
`timescale 1ns/1ps
module scl_cfg_host (
  // device side
  input  wire logic  i_flash_select_n,
  input  wire logic  i_dev_clock,
  input  wire logic  i_status_oe,
  // host and flash pins
  output logic       o_status_wire,
  output logic       o_host_clock,
  output logic       o_host_data,
  output logic [3:0] o_quad_bus
);
  logic       hold_low;
  logic [3:0] nib;

  initial begin
    hold_low = 1'h0;
    nib = 4'h0;
    o_host_clock = 1'h0;
    o_host_data = 1'h0;
  end

  // pulled up; either party may pull it low
  assign o_status_wire = !(i_status_oe || hold_low);
  // new nibble each fall, after a short hold time
  always @(negedge i_dev_clock) nib <= #10 nib + 4'h3;
  // released bus shows the inverse, never a stale copy
  assign o_quad_bus = i_flash_select_n ? ~nib : nib;

  ////////////////////////////////////////
  task automatic hold_status(input logic h);
    hold_low = h;
  endtask

  task automatic set_data(input logic d);
    o_host_data = d;
  endtask

  // clock rests low between frames
  task automatic send_bits(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      o_host_data = v[i];
      #200 o_host_clock = 1'h1;
      #200 o_host_clock = 1'h0;
    end
    o_host_data = ~o_host_data;
  endtask

  task automatic two_falls();
    repeat (2) begin
      #200 o_host_clock = 1'h1;
      #200 o_host_clock = 1'h0;
    end
  endtask
endmodule

// [dv/scl_loader_tb_top.sv]
`timescale 1ns/1ps
`include "scl_map.svh"
module scl_loader_tb_top
  import scl_pkg::*;
;
  localparam int STAT   = 40;
  localparam int CFG    = 16;
  localparam int POR    = 20;
  localparam int USR    = 8;
  localparam int UM_MIN = `SCL_T_CD2UM_MIN_US * `SCL_CLK_MHZ;
  localparam int UM_MAX = `SCL_T_CD2UM_MAX_US * `SCL_CLK_MHZ;

  logic        clk, rstn, as_r, quad, mdev, use_usr, req_n, ucl;
  scl_rate_t   rate;
  logic        st_oe, cpl, config_clock, config_clock_oe, so, sel_n, user_md, uio;
  logic        ido_oe, valid, wide, st_wire, h_clk, h_data;
  logic        st_n, ido, ido_opt, dpu;
  logic        cfg_clk, pck, psel, pso;
  logic [3:0]  bits, qbus;
  logic [15:0] cap;
  logic [31:0] cmd;
  int          nb, cb, tog, cyc, cd, num_errors, n_compared;

  assign cfg_clk = config_clock_oe ? config_clock : h_clk;

  scl_loader #(
    .CONFIG_BITS    (CFG),
    .POR_CYC        (POR),
    .STATUS_MIN_CYC (STAT),
    .USR_INIT_CYC   (USR)
  ) DUT (
    .i_clk                  (clk),
    .i_rstn                 (rstn),
    .i_active_serial_scheme (as_r),
    .i_quad_mode            (quad),
    .i_rate_sel             (rate),
    .i_multi_device         (mdev),
    .i_use_user_clk         (use_usr),
    .i_init_done_opt        (ido_opt),
    .i_data_pin_user        (dpu),
    .i_config_request_n     (req_n),
    .i_config_status_n      (st_wire),
    .o_config_status_n      (st_n),
    .o_config_status_n_oe   (st_oe),
    .o_config_complete      (cpl),
    .i_config_clock         (cfg_clk),
    .o_config_clock         (config_clock),
    .o_config_clock_oe      (config_clock_oe),
    .i_serial_config_data   (h_data),
    .i_quad_flash_bus       (qbus),
    .o_flash_serial_out     (so),
    .o_flash_select_n       (sel_n),
    .i_user_init_clock      (ucl),
    .o_init_done            (ido),
    .o_init_done_oe         (ido_oe),
    .o_user_mode            (user_md),
    .o_user_io_data         (uio),
    .o_cfg_bits             (bits),
    .o_cfg_bits_wide        (wide),
    .o_cfg_valid            (valid)
  );

  scl_cfg_host host (
    .i_flash_select_n (sel_n),
    .i_dev_clock      (config_clock),
    .i_status_oe      (st_oe),
    .o_status_wire    (st_wire),
    .o_host_clock     (h_clk),
    .o_host_data      (h_data),
    .o_quad_bus       (qbus)
  );

  always #25 clk = ~clk;

  ////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'h1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // monitor sees registered outputs, so one-cycle history is exact
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pck <= config_clock;
    psel <= sel_n;
    pso <= so;
    // cycles since complete rose, for the initialization window
    if (!cpl) cd <= 0;
    else cd <= cd + 1;
    if (config_clock !== pck) tog <= tog + 1;
    if (st_oe) nb <= 0;
    else if (valid) begin
      nb <= nb + (wide ? 4 : 1);
      cap <= {cap[14:0], bits[0]};
    end
    if (st_oe) cb <= 0;
    else if (!pck && config_clock && !sel_n && cb < 32) begin
      cmd <= {cmd[30:0], so};
      cb <= cb + 1;
    end
    if (valid && cpl && nb + (wide ? 4 : 1) < CFG) begin
      chk(1'h0, "complete before all data");
    end
    if (!sel_n && !psel && so !== pso) begin
      chk(pck && !config_clock, "flash output moved off a fall");
    end
    if (cyc == 40000) begin
      chk(1'h0, "timeout");
      end_of_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic uclk(input int n);
    repeat (n) begin
      #200 ucl = 1'h1;
      #200 ucl = 1'h0;
    end
  endtask

  task automatic wait_hi(input logic um, output int c);
    c = 0;
    while ((um ? user_md : cpl) !== 1'h1 && c < 9000) begin
      tick(1);
      c++;
    end
  endtask

  ////////////////////////////////////////
  task automatic por_check();
    repeat (POR - 2) begin
      chk(st_oe === 1'h1 && cpl === 1'h0, "power-on status");
      tick(1);
    end
    tick(10);
    chk(st_oe === 1'h0, "status not released");
  endtask

  task automatic restart(input logic hold);
    int k, on, off;
    on = -1;
    off = -1;
    req_n = 1'h0;
    for (k = 1; k < 300 && off < 0; k++) begin
      tick(1);
      if (k == 40) begin
        req_n = 1'h1;
        host.hold_status(hold);
      end
      if (on < 0 && st_oe === 1'h1 && cpl === 1'h0) on = k;
      if (on > 0 && st_oe === 1'h0) off = k;
    end
    chk(on > 0 && on <= 12, "status or complete late");
    chk(st_n === 1'h0 && ido === 1'h0, "open-drain level");
    chk(off - on >= STAT, "status low too short");
    chk(off > 40 && off - 40 <= STAT, "status release late");
  endtask

  task automatic passive_load(input logic usr);
    int c;
    as_r = 1'h0;
    use_usr = usr;
    ido_opt = !usr;
    dpu = !usr;
    restart(1'h1);
    host.send_bits(16'ha5c3);
    chk(nb == 0 && cpl === 1'h0, "load ran while held");
    host.hold_status(1'h0);
    tick(50);
    host.send_bits(16'h1e6b);
    tick(8);
    chk(nb == CFG && cap === 16'h1e6b, "serial data lost");
    chk(cpl === 1'h1, "complete not raised");
    host.two_falls();
    tick(30);
    chk(ido_oe === ido_opt && user_md === 1'h0, "init ended early");
    if (usr) begin
      uclk(7);
      tick(6);
      chk(user_md === 1'h0, "user clock init too short");
      uclk(3);
    end
    wait_hi(1'h1, c);
    chk(usr || (cd >= UM_MIN && cd <= UM_MAX), "osc init");
    chk(user_md === 1'h1 && ido_oe === 1'h0, "no user mode");
    host.set_data(1'h1);
    tick(8);
    chk(uio === dpu, "data pin not passed");
    host.set_data(1'h0);
    tick(8);
    chk(uio === 1'h0, "data pin stuck");
  endtask

  task automatic active_load(input scl_rate_t r, input logic md,
                             input logic q, input int half);
    int c;
    as_r = 1'h1;
    rate = r;
    mdev = md;
    quad = q;
    use_usr = 1'h0;
    restart(1'h0);
    c = 0;
    while (sel_n !== 1'h0 && c < 200) begin
      tick(1);
      c++;
    end
    tick(4);
    tog = 0;
    tick(48);
    chk(tog >= 48 / half - 1 && tog <= 48 / half + 1, "rate");
    wait_hi(1'h0, c);
    tick(2);
    chk(nb == CFG && wide === q, "width or count");
    chk(cmd === `SCL_RD_WORD, "flash command");
    wait_hi(1'h1, c);
    chk(user_md === 1'h1 && cd >= UM_MIN && cd <= UM_MAX, "init time");
  endtask

  ////////////////////////////////////////
  initial begin
    clk = 1'h0;
    rstn = 1'h0;
    as_r = 1'h0;
    quad = 1'h0;
    mdev = 1'h0;
    use_usr = 1'h0;
    req_n = 1'h1;
    ucl = 1'h0;
    ido_opt = 1'h1;
    dpu = 1'h1;
    rate = 2'h0;
    cap = 16'h0;
    cmd = 32'h0;
    nb = 0;
    cb = 0;
    tog = 0;
    cyc = 0;
    num_errors = 0;
    n_compared = 0;
    tick(20);
    rstn = 1'h1;
    por_check();
    passive_load(1'h0);
    passive_load(1'h1);
    active_load(2'h0, 1'h0, 1'h0, 8);
    active_load(2'h1, 1'h0, 1'h1, 4);
    active_load(2'h2, 1'h0, 1'h1, 2);
    active_load(2'h3, 1'h0, 1'h1, 1);
    active_load(2'h3, 1'h1, 1'h1, 2);
    end_of_test();
  end
endmodule
